//--- core/sdp_cfg.svh
/*
 holds the numeric constants of the dual element datapath: field positions,
 widths, register file geometry and opcode width. assumes it is included by bare name.
*/
`ifndef SDP_CFG_SVH
`define SDP_CFG_SVH
`define SDP_WORD_W 40
`define SDP_REG_IDX_W 4
`define SDP_BANK_REGS 16
`define SDP_SIGN_BIT 39
`define SDP_FLAG_ZERO 0
`define SDP_FLAG_NEG 1
`define SDP_FLAG_W 2
`define SDP_OP_W 3
`define SDP_MODE_SEC_EN 0
`define SDP_MODE_W 2
`define SDP_MODE_BANK_SEL 1
`define SDP_FMT_W 2
`define SDP_LOW32_W 32
`define SDP_PAD8 8'h00
`define SDP_ZERO40 40'h00_0000_0000
`define SDP_CACHE_DEPTH 32
`define SDP_PC_W 24
`define SDP_INSN_W 48
`endif

//--- core/sdp_pkg.sv
/*
 types shared by the datapath top and its processing element.
 assumes sdp_cfg.svh is reachable on the include path.
*/
`include "sdp_cfg.svh"
package sdp_pkg;
   typedef enum logic [`SDP_OP_W-1:0] {
      SDP_ALU_NOP, SDP_ALU_ADD, SDP_ALU_SUB, SDP_ALU_AND, SDP_ALU_OR, SDP_ALU_PASS
   } sdp_alu_op_t;
   typedef enum logic [`SDP_OP_W-1:0] {
      SDP_MUL_NOP, SDP_MUL_MUL, SDP_MUL_MAC
   } sdp_mul_op_t;
   typedef enum logic [`SDP_OP_W-1:0] {
      SDP_SH_NOP, SDP_SH_LSL, SDP_SH_LSR, SDP_SH_ASR
   } sdp_sh_op_t;
   typedef enum logic [`SDP_FMT_W-1:0] {
      SDP_FMT_FIX32, SDP_FMT_FLT32, SDP_FMT_FLT40
   } sdp_fmt_t;
   typedef struct packed {
      sdp_alu_op_t alu_op;
      sdp_mul_op_t mul_op;
      sdp_sh_op_t sh_op;
      sdp_fmt_t fmt;
      logic [`SDP_REG_IDX_W-1:0] src_a;
      logic [`SDP_REG_IDX_W-1:0] src_b;
      logic [`SDP_REG_IDX_W-1:0] alu_dst;
      logic [`SDP_REG_IDX_W-1:0] mul_dst;
      logic [`SDP_REG_IDX_W-1:0] sh_dst;
      logic [`SDP_REG_IDX_W-1:0] shift_amt;
   } sdp_insn_t;
   typedef struct packed {
      logic dm_ld;
      logic dm_st;
      logic [`SDP_REG_IDX_W-1:0] dm_reg;
      logic pm_ld;
      logic pm_st;
      logic [`SDP_REG_IDX_W-1:0] pm_reg;
   } sdp_xfer_t;
endpackage

//--- core/sdp_element.sv
/*
 one processing element: banked register file, alu, multiplier and shifter
 in parallel, all single cycle. assumes the caller gates it with an enable.
*/
`timescale 1ns/1ps
`include "sdp_cfg.svh"
module sdp_element #(
   parameter int W = `SDP_WORD_W,
   parameter int NREG = `SDP_BANK_REGS
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic active,
   input wire logic bank_sel,
   input wire sdp_pkg::sdp_insn_t insn,
   input wire sdp_pkg::sdp_xfer_t xfer,
   input wire logic [W-1:0] dm_in,
   input wire logic [W-1:0] pm_in,
   output logic [W-1:0] dm_out,
   output logic [W-1:0] pm_out,
   output logic [`SDP_FLAG_W-1:0] flags
);
   logic [W-1:0] rf_q [2*NREG];
   logic [W-1:0] rf_d [2*NREG];
   logic [`SDP_FLAG_W-1:0] flags_q, flags_d;
   logic [W-1:0] a, b, alu_r, mul_r, sh_r;
   logic [2*W-1:0] prod;
   logic [4:0] base;
   always_comb begin
      base = bank_sel ? 5'(NREG) : 5'h0_0;
      a = rf_q[base + 5'(insn.src_a)];
      b = rf_q[base + 5'(insn.src_b)];
      // fixed and 32-bit float formats live in the upper 32 bits, low byte zero
      if (insn.fmt != sdp_pkg::SDP_FMT_FLT40) begin
         a[7:0] = `SDP_PAD8;
         b[7:0] = `SDP_PAD8;
      end
      case (insn.alu_op)
         sdp_pkg::SDP_ALU_ADD: alu_r = a + b;
         sdp_pkg::SDP_ALU_SUB: alu_r = a - b;
         sdp_pkg::SDP_ALU_AND: alu_r = a & b;
         sdp_pkg::SDP_ALU_OR: alu_r = a | b;
         sdp_pkg::SDP_ALU_PASS: alu_r = a;
         default: alu_r = a;
      endcase
      prod = a * b;
      // integer product scaled back to word width; mac accumulates into destination
      mul_r = prod[2*W-1-8 -: W];
      if (insn.mul_op == sdp_pkg::SDP_MUL_MAC) begin
         mul_r = mul_r + rf_q[base + 5'(insn.mul_dst)];
      end
      case (insn.sh_op)
         sdp_pkg::SDP_SH_LSL: sh_r = a << insn.shift_amt;
         sdp_pkg::SDP_SH_LSR: sh_r = a >> insn.shift_amt;
         sdp_pkg::SDP_SH_ASR: sh_r = W'($signed(a) >>> insn.shift_amt);
         default: sh_r = a;
      endcase
      rf_d = rf_q;
      flags_d = flags_q;
      if (active) begin
         // units run in parallel; later writes win on a shared destination
         if (insn.sh_op != sdp_pkg::SDP_SH_NOP) rf_d[base + 5'(insn.sh_dst)] = sh_r;
         if (insn.alu_op != sdp_pkg::SDP_ALU_NOP) begin
            rf_d[base + 5'(insn.alu_dst)] = alu_r;
            flags_d[`SDP_FLAG_ZERO] = (alu_r == `SDP_ZERO40);
            flags_d[`SDP_FLAG_NEG] = alu_r[`SDP_SIGN_BIT];
         end
         if (insn.mul_op != sdp_pkg::SDP_MUL_NOP) rf_d[base + 5'(insn.mul_dst)] = mul_r;
         if (xfer.dm_ld) rf_d[base + 5'(xfer.dm_reg)] = dm_in;
         if (xfer.pm_ld) rf_d[base + 5'(xfer.pm_reg)] = pm_in;
      end
   end
   always_ff @(posedge clock) begin
      if (!rstn) begin
         for (int i = 0; i < 2*NREG; i++) rf_q[i] <= '0;
         flags_q <= '0;
      end else begin
         rf_q <= rf_d;
         flags_q <= flags_d;
      end
   end
   assign dm_out = rf_q[base + 5'(xfer.dm_reg)];
   assign pm_out = rf_q[base + 5'(xfer.pm_reg)];
   assign flags = flags_q;
endmodule

//--- core/sdp_datapath.sv
/*
 dual element simd datapath top: mode control, two processing elements,
 doubled memory transfers and the conflict-only instruction cache.
 assumes the sequencer drives instruction and transfer fields on the same clock.
*/
`timescale 1ns/1ps
`include "sdp_cfg.svh"
// Notes on behaviour
// - primary always runs; secondary only when enabled
// - enabled: same instruction, both elements, own data
// - dual mode moves two values per access
// - alu, multiplier, shifter single cycle, parallel
// - multifunction instruction runs alu and multiplier together
// - fixed32, float32 and float40 operands accepted
// - 32 registers per element, ten access ports
// - four operands plus cached instruction per cycle
// - cache only instructions colliding with pm data
module sdp_datapath #(
   parameter int W = `SDP_WORD_W,
   parameter int CDEPTH = `SDP_CACHE_DEPTH
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic mode_wr,
   input wire logic [`SDP_MODE_W-1:0] mode_wdata,
   input wire logic issue,
   input wire sdp_pkg::sdp_insn_t insn,
   input wire sdp_pkg::sdp_xfer_t xfer,
   input wire logic [`SDP_PC_W-1:0] fetch_pc,
   input wire logic [`SDP_INSN_W-1:0] fetch_word,
   input wire logic fetch_word_valid,
   input wire logic [W-1:0] dm_rdata_pri,
   input wire logic [W-1:0] dm_rdata_sec,
   input wire logic [W-1:0] pm_rdata_pri,
   input wire logic [W-1:0] pm_rdata_sec,
   output logic [`SDP_MODE_W-1:0] mode_control_register,
   output logic [W-1:0] dm_wdata_pri,
   output logic [W-1:0] dm_wdata_sec,
   output logic [W-1:0] pm_wdata_pri,
   output logic [W-1:0] pm_wdata_sec,
   output logic dm_we_pri,
   output logic dm_we_sec,
   output logic pm_we_pri,
   output logic pm_we_sec,
   output logic cache_hit,
   output logic [`SDP_INSN_W-1:0] cache_insn,
   output logic [`SDP_FLAG_W-1:0] flags_pri,
   output logic [`SDP_FLAG_W-1:0] flags_sec
);
   localparam int CI = $clog2(CDEPTH);
   logic [`SDP_MODE_W-1:0] mode_q, mode_d;
   logic sec_en, pm_conflict;
   sdp_pkg::sdp_xfer_t xfer_sec;
   logic [W-1:0] dmo_p, dmo_s, pmo_p, pmo_s;
   logic [W-1:0] dmw_p_q;
   logic [W-1:0] dmw_p_d;
   logic [W-1:0] dmw_s_q;
   logic [W-1:0] dmw_s_d;
   logic [W-1:0] pmw_p_q;
   logic [W-1:0] pmw_p_d;
   logic [W-1:0] pmw_s_q;
   logic [W-1:0] pmw_s_d;
   logic dwe_p_q;
   logic dwe_p_d;
   logic dwe_s_q;
   logic dwe_s_d;
   logic pwe_p_q;
   logic pwe_p_d;
   logic pwe_s_q;
   logic pwe_s_d;
   logic [`SDP_FLAG_W-1:0] fl_p, fl_s, flp_q, fls_q, flp_d, fls_d;
   logic [`SDP_INSN_W-1:0] c_data_q [CDEPTH];
   logic [`SDP_INSN_W-1:0] c_data_d [CDEPTH];
   logic [`SDP_PC_W-1:0] c_tag_q [CDEPTH];
   logic [`SDP_PC_W-1:0] c_tag_d [CDEPTH];
   logic [CDEPTH-1:0] c_val_q, c_val_d;
   logic hit_q, hit_d;
   logic [`SDP_INSN_W-1:0] ci_q, ci_d;
   logic [CI-1:0] idx;

   always_comb begin
      mode_d = mode_q;
      if (mode_wr) mode_d = mode_wdata;
   end
   assign sec_en = mode_q[`SDP_MODE_SEC_EN];

   // secondary sees the same transfer fields, but only while enabled
   always_comb begin
      xfer_sec = xfer;
      if (!sec_en || !issue) xfer_sec = '0;
   end

   sdp_element #(.W(W), .NREG(`SDP_BANK_REGS)) u_primary (
      .clock(clock),
      .rstn(rstn),
      .active(issue),
      .bank_sel(mode_q[`SDP_MODE_BANK_SEL]),
      .insn(insn),
      .xfer(xfer),
      .dm_in(dm_rdata_pri),
      .pm_in(pm_rdata_pri),
      .dm_out(dmo_p),
      .pm_out(pmo_p),
      .flags(fl_p)
   );
   // same instruction word, own operand data
   sdp_element #(.W(W), .NREG(`SDP_BANK_REGS)) u_secondary (
      .clock(clock),
      .rstn(rstn),
      .active(issue && sec_en),
      .bank_sel(mode_q[`SDP_MODE_BANK_SEL]),
      .insn(insn),
      .xfer(xfer_sec),
      .dm_in(dm_rdata_sec),
      .pm_in(pm_rdata_sec),
      .dm_out(dmo_s),
      .pm_out(pmo_s),
      .flags(fl_s)
   );

   // dm and pm stores each carry two values in dual mode
   always_comb begin
      dmw_p_d = dmo_p;
      pmw_p_d = pmo_p;
      dmw_s_d = sec_en ? dmo_s : dmw_s_q;
      pmw_s_d = sec_en ? pmo_s : pmw_s_q;
      dwe_p_d = issue && xfer.dm_st;
      pwe_p_d = issue && xfer.pm_st;
      dwe_s_d = xfer_sec.dm_st;
      pwe_s_d = xfer_sec.pm_st;
   end

   // cache fills only on a pm data collision; hits need no pm fetch
   assign pm_conflict = issue && (xfer.pm_ld || xfer.pm_st);
   assign idx = fetch_pc[CI-1:0];
   always_comb begin
      c_data_d = c_data_q;
      c_tag_d = c_tag_q;
      c_val_d = c_val_q;
      hit_d = c_val_q[idx] && (c_tag_q[idx] == fetch_pc);
      ci_d = c_data_q[idx];
      if (pm_conflict && fetch_word_valid && !hit_d) begin
         c_data_d[idx] = fetch_word;
         c_tag_d[idx] = fetch_pc;
         c_val_d[idx] = 1'b1;
      end
   end

   // flags take one stage so every output leaves a flop; a disabled secondary already holds its own
   always_comb begin
      flp_d = fl_p;
      fls_d = fl_s;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         mode_q <= '0;
      end else begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         dmw_p_q <= '0;
         dmw_s_q <= '0;
         pmw_p_q <= '0;
         pmw_s_q <= '0;
         dwe_p_q <= 1'b0;
         dwe_s_q <= 1'b0;
         pwe_p_q <= 1'b0;
         pwe_s_q <= 1'b0;
      end else begin
         dmw_p_q <= dmw_p_d;
         dmw_s_q <= dmw_s_d;
         pmw_p_q <= pmw_p_d;
         pmw_s_q <= pmw_s_d;
         dwe_p_q <= dwe_p_d;
         dwe_s_q <= dwe_s_d;
         pwe_p_q <= pwe_p_d;
         pwe_s_q <= pwe_s_d;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         flp_q <= '0;
         fls_q <= '0;
      end else begin
         flp_q <= flp_d;
         fls_q <= fls_d;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         c_val_q <= '0;
         hit_q <= 1'b0;
         ci_q <= '0;
         for (int i = 0; i < CDEPTH; i++) begin
            c_data_q[i] <= '0;
            c_tag_q[i] <= '0;
         end
      end else begin
         c_val_q <= c_val_d;
         c_data_q <= c_data_d;
         c_tag_q <= c_tag_d;
         hit_q <= hit_d;
         ci_q <= ci_d;
      end
   end

   assign mode_control_register = mode_q;
   assign dm_wdata_pri = dmw_p_q;
   assign dm_wdata_sec = dmw_s_q;
   assign pm_wdata_pri = pmw_p_q;
   assign pm_wdata_sec = pmw_s_q;
   assign dm_we_pri = dwe_p_q;
   assign dm_we_sec = dwe_s_q;
   assign pm_we_pri = pwe_p_q;
   assign pm_we_sec = pwe_s_q;
   assign cache_hit = hit_q;
   assign cache_insn = ci_q;
   assign flags_pri = flp_q;
   assign flags_sec = fls_q;
endmodule

//--- dv/sdp_mem_model.sv
/*
 memory partner on the data and program buses: one word per lane, 0/1 data bus pri/sec, 2/3 program bus pri/sec.
 assumes store strobes and data arrive on the core clock.
*/
`timescale 1ns/1ps
module sdp_mem_model (
   input wire logic clock,
   input wire logic [3:0] we,
   input wire logic [3:0][39:0] wdata,
   output logic [3:0][39:0] rdata
);
   // preset so loads return known operands before any store; low byte of lane 0 set to expose format handling
   initial rdata = {40'h00_0000_0500, 40'h00_0000_0300, 40'h02_0000_0000, 40'h01_0000_0077};
   always @(posedge clock) begin
      for (int i = 0; i < 4; i++) begin
         if (we[i]) begin
            rdata[i] <= wdata[i];
         end
      end
   end
endmodule

//--- dv/sdp_datapath_monitor.sv
/*
 checker on the datapath top ports: mode load, store strobes, lane pairing, frozen secondary.
 assumes it is bound to sdp_datapath, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "sdp_cfg.svh"
module sdp_datapath_monitor (
   input wire logic clock,
   input wire logic rstn,
   input wire logic mode_wr,
   input wire logic [`SDP_MODE_W-1:0] mode_wdata,
   input wire logic issue,
   input wire sdp_pkg::sdp_xfer_t xfer,
   input wire logic [`SDP_MODE_W-1:0] mode_control_register,
   input wire logic dm_we_pri,
   input wire logic dm_we_sec,
   input wire logic pm_we_pri,
   input wire logic pm_we_sec,
   input wire logic [`SDP_FLAG_W-1:0] flags_sec
);
   logic sec_en;
   assign sec_en = mode_control_register[`SDP_MODE_SEC_EN];
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   mode_load_a:
      assert property (mode_wr |=> mode_control_register == $past(mode_wdata)) else $error("mode load wrong");
   dm_store_a:
      assert property (issue && xfer.dm_st |=> dm_we_pri) else $error("primary store strobe missing");
   dm_quiet_a:
      assert property (!(issue && xfer.dm_st) |=> !dm_we_pri) else $error("stray primary store strobe");
   lane_pair_a:
      assert property (dm_we_sec |-> dm_we_pri) else $error("secondary store without primary");
   dm_dual_a:
      assert property (issue && xfer.dm_st && sec_en |=> dm_we_sec) else $error("dual store not doubled");
   pm_dual_a:
      assert property (issue && xfer.pm_st |=> pm_we_pri && pm_we_sec == $past(sec_en)) else $error("pm store wrong");
   sec_gate_a:
      assert property (!$past(sec_en) |-> !dm_we_sec && !pm_we_sec) else $error("disabled secondary stored");
   // three cycles of history cover the two-cycle flag latency of an issue made while enabled
   sec_flags_a:
      assert property (!sec_en && !$past(sec_en) && !$past(sec_en, 2) && !$past(sec_en, 3) |-> $stable(flags_sec))
         else $error("disabled secondary flags moved");
endmodule
bind sdp_datapath sdp_datapath_monitor mon_u (.clock(clock), .rstn(rstn), .mode_wr(mode_wr),
   .mode_wdata(mode_wdata), .issue(issue), .xfer(xfer), .mode_control_register(mode_control_register),
   .dm_we_pri(dm_we_pri), .dm_we_sec(dm_we_sec), .pm_we_pri(pm_we_pri), .pm_we_sec(pm_we_sec),
   .flags_sec(flags_sec));

//--- dv/sdp_datapath_tb.sv
/*
 self-checking bench for the datapath: formats, dual lanes, frozen secondary, selective cache.
 assumes the memory model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`include "sdp_cfg.svh"
module sdp_datapath_tb;
   logic clock, rstn, mode_wr, issue, fetch_word_valid, cache_hit;
   logic [`SDP_MODE_W-1:0] mode_wdata, mode_control_register;
   sdp_pkg::sdp_insn_t insn;
   sdp_pkg::sdp_xfer_t xfer;
   logic [`SDP_PC_W-1:0] fetch_pc;
   logic [`SDP_INSN_W-1:0] fetch_word, cache_insn;
   logic [`SDP_FLAG_W-1:0] flags_pri, flags_sec;
   wire [3:0][39:0] rd, wd;
   wire [3:0] we;
   int mismatches, num_checks, cycles;
   sdp_datapath dut_u (.clock(clock), .rstn(rstn), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .issue(issue),
      .insn(insn), .xfer(xfer), .fetch_pc(fetch_pc), .fetch_word(fetch_word), .fetch_word_valid(fetch_word_valid),
      .dm_rdata_pri(rd[0]), .dm_rdata_sec(rd[1]), .pm_rdata_pri(rd[2]), .pm_rdata_sec(rd[3]),
      .mode_control_register(mode_control_register), .dm_wdata_pri(wd[0]), .dm_wdata_sec(wd[1]),
      .pm_wdata_pri(wd[2]), .pm_wdata_sec(wd[3]), .dm_we_pri(we[0]), .dm_we_sec(we[1]), .pm_we_pri(we[2]),
      .pm_we_sec(we[3]), .cache_hit(cache_hit), .cache_insn(cache_insn), .flags_pri(flags_pri),
      .flags_sec(flags_sec));
   sdp_mem_model mem_u (.clock(clock), .we(we), .wdata(wd), .rdata(rd));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task check(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task run(input sdp_pkg::sdp_insn_t i, input sdp_pkg::sdp_xfer_t x);
      @(posedge clock);
      issue <= 1'b1;
      insn <= i;
      xfer <= x;
   endtask
   task idle;
      @(posedge clock);
      issue <= 1'b0;
      insn <= '0;
      xfer <= '0;
      fetch_word_valid <= 1'b0;
      mode_wr <= 1'b0;
   endtask
   task set_mode(input logic [1:0] m);
      @(posedge clock);
      mode_wr <= 1'b1;
      mode_wdata <= m;
      idle;
      #1 check(mode_control_register, m);
   endtask
   // single lane: pass r2 through every operand format, back-to-back with its store
   task t_single;
      sdp_pkg::sdp_insn_t op;
      run('0, '{1'b1, 1'b0, 4'd2, 1'b0, 1'b0, 4'd0});
      for (int f = 0; f < 3; f++) begin
         op = '{sdp_pkg::SDP_ALU_PASS, sdp_pkg::SDP_MUL_NOP, sdp_pkg::SDP_SH_NOP, sdp_pkg::sdp_fmt_t'(f),
            4'd2, 4'd2, 4'd5, 4'd6, 4'd7, 4'd0};
         run(op, '0);
         run('0, '{1'b0, 1'b1, 4'd5, 1'b0, 1'b0, 4'd0});
         idle;
         #1 check(wd[0], f == 2 ? 40'h01_0000_0077 : 40'h01_0000_0000);
         check(we, 4'b0001);
      end
   endtask
   // dual lanes: two loads on both buses, add and multiply at once, doubled stores
   task t_dual;
      set_mode(2'b01);
      run('0, '{1'b1, 1'b0, 4'd2, 1'b1, 1'b0, 4'd3});
      run('{sdp_pkg::SDP_ALU_ADD, sdp_pkg::SDP_MUL_MUL, sdp_pkg::SDP_SH_NOP, sdp_pkg::SDP_FMT_FIX32,
         4'd2, 4'd3, 4'd1, 4'd4, 4'd5, 4'd0}, '0);
      run('0, '{1'b0, 1'b1, 4'd1, 1'b0, 1'b1, 4'd4});
      idle;
      #1 check(wd[0], 40'h01_0000_0300);
      check(wd[1], 40'h02_0000_0500);
      check(wd[2], 40'h00_0000_0300);
      check(wd[3], 40'h00_0000_0A00);
      check(we, 4'b1111);
   endtask
   // disabled secondary ignores a load, then still holds its old sum when re-enabled
   task t_freeze;
      set_mode(2'b00);
      run('0, '{1'b0, 1'b0, 4'd0, 1'b1, 1'b0, 4'd1});
      run('{sdp_pkg::SDP_ALU_SUB, sdp_pkg::SDP_MUL_NOP, sdp_pkg::SDP_SH_NOP, sdp_pkg::SDP_FMT_FIX32,
         4'd1, 4'd1, 4'd7, 4'd8, 4'd9, 4'd0}, '{1'b0, 1'b1, 4'd1, 1'b0, 1'b0, 4'd0});
      idle;
      #1 check(we, 4'b0001);
      set_mode(2'b01);
      run('0, '{1'b0, 1'b1, 4'd1, 1'b0, 1'b0, 4'd0});
      idle;
      #1 check(wd[1], 40'h02_0000_0500);
      check(we, 4'b0011);
      check(flags_pri, 2'b01);
      check(flags_sec, 2'b00);
   endtask
   // a fetch without program bus data must not allocate; a colliding one must
   task t_cache;
      @(posedge clock);
      issue <= 1'b1;
      fetch_pc <= 24'h00_0040;
      fetch_word <= 48'h1234_5678_9ABC;
      fetch_word_valid <= 1'b1;
      idle;
      idle;
      #1 check(cache_hit, 1'b0);
      run('0, '{1'b0, 1'b0, 4'd0, 1'b1, 1'b0, 4'd6});
      fetch_word_valid <= 1'b1;
      idle;
      idle;
      #1 check(cache_hit, 1'b1);
      check(cache_insn, 48'h1234_5678_9ABC);
   endtask
   // upper bank hides the lower r1, and the lower one survives the round trip
   task t_bank;
      set_mode(2'b10);
      run('0, '{1'b0, 1'b1, 4'd1, 1'b0, 1'b0, 4'd0});
      idle;
      #1 check(wd[0], 40'h00_0000_0000);
      set_mode(2'b00);
      run('0, '{1'b0, 1'b1, 4'd1, 1'b0, 1'b0, 4'd0});
      idle;
      #1 check(wd[0], 40'h00_0000_0300);
      check(we, 4'b0001);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         stop_test;
      end
   end
   initial begin
      rstn = 1'b0;
      mode_wr = 1'b0;
      mode_wdata = '0;
      issue = 1'b0;
      insn = '0;
      xfer = '0;
      fetch_pc = '0;
      fetch_word = '0;
      fetch_word_valid = 1'b0;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      idle;
      t_single;
      t_dual;
      t_freeze;
      t_cache;
      t_bank;
      repeat (4) @(posedge clock);
      stop_test;
   end
endmodule
